// ### sensor_cmd_pkg.sv
package sensor_cmd_pkg;

  // command words
  localparam logic [15:0] CMD_GET_SERIAL   = 16'hD033;
  localparam logic [15:0] CMD_GET_VERSION  = 16'hD100;
  localparam logic [15:0] CMD_READ_STATUS  = 16'hD206;
  localparam logic [15:0] CMD_CLEAR_STATUS = 16'hD210;
  localparam logic [15:0] CMD_DEVICE_RESET = 16'hD304;

  // checksum
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // response layout
  localparam int          SERIAL_CHARS   = 32;
  localparam int          SERIAL_BITS    = SERIAL_CHARS * 8;
  localparam int          SERIAL_WORDS   = SERIAL_CHARS / 2;
  localparam int          GRP_W          = 5;
  localparam logic [GRP_W-1:0] SERIAL_GROUPS  = 5'h10;
  localparam logic [GRP_W-1:0] VERSION_GROUPS = 5'h04;
  localparam logic [GRP_W-1:0] STATUS_GROUPS  = 5'h02;
  localparam logic [1:0]  POS_MSB        = 2'h0;
  localparam logic [1:0]  POS_LSB        = 2'h1;
  localparam logic [1:0]  POS_CRC        = 2'h2;
  localparam logic [7:0]  IDLE_BYTE      = 8'hFF;
  localparam logic [7:0]  PAD_BYTE       = 8'h00;

  // version defaults (arbitrary values)
  localparam logic [7:0] FW_MAJOR_DEF = 8'h01;
  localparam logic [7:0] FW_MINOR_DEF = 8'h00;
  localparam logic [7:0] HW_MAJOR_DEF = 8'h01;
  localparam logic [7:0] HW_MINOR_DEF = 8'h00;
  localparam logic [7:0] PR_MAJOR_DEF = 8'h01;
  localparam logic [7:0] PR_MINOR_DEF = 8'h00;

  // status word
  localparam int          STATUS_W        = 32;
  localparam logic [31:0] ERROR_FLAG_MASK = 32'hFFFF_0000;

  // timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int READ_DELAY_MS = 20;
  localparam int RESET_TIME_MS = 1200;
  localparam int READ_DELAY_CYC = READ_DELAY_MS * (CLK_HZ / 1000);
  localparam int RESET_CYC      = RESET_TIME_MS * (CLK_HZ / 1000);
  localparam int CNT_W          = 32;

  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_SERIAL,
    RESP_VERSION,
    RESP_STATUS
  } resp_e;

endpackage : sensor_cmd_pkg

// ### crc8_pair.sv
`timescale 1ns/10ps
`default_nettype none
module crc8_pair
  import sensor_cmd_pkg::*;
(
  input  wire logic [15:0] i_word,
  output logic      [7:0]  o_crc
);
  always_comb begin
    logic [7:0] c;
    logic       fb;
    c  = CRC_INIT;
    fb = 1'b0;
    // msb first, one bit per step, equals the byte-wise form
    for (int b = 15; b >= 0; b--) begin
      fb = c[7] ^ i_word[b];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    o_crc = c;
  end
endmodule : crc8_pair
`default_nettype wire

// ### status_word_keeper.sv
`timescale 1ns/10ps
`default_nettype none
module status_word_keeper
  import sensor_cmd_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_sys_rst,
  input  wire logic [STATUS_W-1:0] i_cond,
  input  wire logic                i_clear,
  output logic      [STATUS_W-1:0] o_flags
);
  logic [STATUS_W-1:0] flags_r;

  for (genvar i = 0; i < STATUS_W; i++) begin : g_flag
    logic flag_nxt;
    // a condition in the clearing cycle still sets the flag
    assign flag_nxt = ERROR_FLAG_MASK[i] ?
                      (i_cond[i] | (flags_r[i] & ~i_clear)) :
                      i_cond[i];
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        flags_r[i] <= 1'b0;
      end else begin
        flags_r[i] <= flag_nxt;
      end
    end
  end

  assign o_flags = flags_r;
endmodule : status_word_keeper
`default_nettype wire

// ### sensor_info_status_commands.sv
// Behaviour
// - serial command: serial string readable once read delay elapsed
// - serial: 32 null-terminated chars, pairs plus checksum, 48 bytes max
// - version command returns up to 12 bytes of revisions
// - version order fw, hw, protocol, padding; checksum after each pair
// - version carries a boolean firmware debug flag
// - status is a 32-bit word, one bit per flag
// - simultaneous conditions report all their bits combined
// - error flags stay set after the cause goes away
// - error flags clear only by read-and-clear or reset command
// - other flags follow their condition directly
// - read status: msb first, two words with checksums, no change
// - read-and-clear returns value before clearing, then clears the error flags
// - reset command reinitializes; host waits 1200 ms afterwards
// - checksum is crc8 poly 0x31 init 0xFF over two bytes
`timescale 1ns/10ps
`default_nettype none
module sensor_info_status_commands
  import sensor_cmd_pkg::*;
#(
  parameter int unsigned                         P_READ_DELAY_CYC = sensor_cmd_pkg::READ_DELAY_CYC,
  parameter int unsigned                         P_RESET_CYC      = sensor_cmd_pkg::RESET_CYC,
  parameter logic [sensor_cmd_pkg::SERIAL_BITS-1:0] P_SERIAL      = '0,
  parameter logic                                P_FW_DEBUG       = 1'b0,
  parameter logic [7:0]                          P_FW_MAJOR       = sensor_cmd_pkg::FW_MAJOR_DEF,
  parameter logic [7:0]                          P_FW_MINOR       = sensor_cmd_pkg::FW_MINOR_DEF,
  parameter logic [7:0]                          P_HW_MAJOR       = sensor_cmd_pkg::HW_MAJOR_DEF,
  parameter logic [7:0]                          P_HW_MINOR       = sensor_cmd_pkg::HW_MINOR_DEF,
  parameter logic [7:0]                          P_PR_MAJOR       = sensor_cmd_pkg::PR_MAJOR_DEF,
  parameter logic [7:0]                          P_PR_MINOR       = sensor_cmd_pkg::PR_MINOR_DEF
) (
  input  wire logic                                i_core_clk,
  input  wire logic                                i_sys_rst,
  input  wire logic                                i_cmd_valid,
  input  wire logic [15:0]                         i_cmd_word,
  input  wire logic                                i_rd_req,
  input  wire logic                                i_rd_stop,
  input  wire logic [sensor_cmd_pkg::STATUS_W-1:0] i_status_cond,
  output logic      [7:0]                          o_rd_data,
  output logic                                     o_rd_valid,
  output logic                                     o_rd_nack,
  output logic                                     o_data_ready,
  output logic                                     o_busy,
  output logic                                     o_soft_rst,
  output logic      [sensor_cmd_pkg::STATUS_W-1:0] o_status_flags
);
  import sensor_cmd_pkg::*;

  // state
  resp_e               resp_r;
  resp_e               resp_nxt;
  logic [STATUS_W-1:0] snap_r;
  logic [CNT_W-1:0]    delay_cnt_r;
  logic                ready_r;
  logic [CNT_W-1:0]    busy_cnt_r;
  logic                busy_r;
  logic                soft_rst_r;
  logic [GRP_W-1:0]    grp_r;
  logic [1:0]          pos_r;
  logic [7:0]          rd_data_r;
  logic                rd_valid_r;
  logic                rd_nack_r;

  // decode
  logic                cmd_take;
  logic                is_serial;
  logic                is_version;
  logic                is_read_st;
  logic                is_clear_st;
  logic                is_reset;
  logic                is_read_cmd;
  logic                status_clear;
  logic [STATUS_W-1:0] flags;

  assign cmd_take     = i_cmd_valid & ~busy_r;
  assign is_serial    = cmd_take & (i_cmd_word == CMD_GET_SERIAL);
  assign is_version   = cmd_take & (i_cmd_word == CMD_GET_VERSION);
  assign is_read_st   = cmd_take & (i_cmd_word == CMD_READ_STATUS);
  assign is_clear_st  = cmd_take & (i_cmd_word == CMD_CLEAR_STATUS);
  assign is_reset     = cmd_take & (i_cmd_word == CMD_DEVICE_RESET);
  assign is_read_cmd  = is_serial | is_version | is_read_st | is_clear_st;
  // clear follows the snapshot taken in the same cycle
  assign status_clear = is_clear_st | is_reset;

  // other command words belong to other blocks and leave our state alone
  always_comb begin
    resp_nxt = resp_r;
    if (is_reset) begin
      resp_nxt = RESP_NONE;
    end else if (is_serial) begin
      resp_nxt = RESP_SERIAL;
    end else if (is_version) begin
      resp_nxt = RESP_VERSION;
    end else if (is_read_st | is_clear_st) begin
      resp_nxt = RESP_STATUS;
    end
  end

  status_word_keeper u_status (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_cond     (i_status_cond),
    .i_clear    (status_clear),
    .o_flags    (flags)
  );

  // response words
  logic [15:0] serial_words [SERIAL_WORDS];
  for (genvar w = 0; w < SERIAL_WORDS; w++) begin : g_serial
    assign serial_words[w] = P_SERIAL[SERIAL_BITS-1-16*w -: 16];
  end

  logic [15:0] version_words [4];
  assign version_words[0] = {P_FW_MAJOR, P_FW_MINOR};
  assign version_words[1] = {7'h00, P_FW_DEBUG, P_HW_MAJOR};
  assign version_words[2] = {P_HW_MINOR, P_PR_MAJOR};
  assign version_words[3] = {P_PR_MINOR, PAD_BYTE};

  logic [GRP_W-1:0] grp_limit;
  logic [15:0]      cur_word;
  logic [7:0]       cur_crc;
  logic             in_range;
  logic [7:0]       cur_byte;

  // index and halves of the word in flight; status goes high half first
  logic [3:0]       serial_idx;
  logic [1:0]       version_idx;
  logic [15:0]      status_hi;
  logic [15:0]      status_lo;
  assign serial_idx  = grp_r[3:0];
  assign version_idx = grp_r[1:0];
  assign status_hi   = snap_r[STATUS_W-1 -: 16];
  assign status_lo   = snap_r[STATUS_W/2-1:0];

  always_comb begin
    grp_limit = '0;
    cur_word  = 16'h0000;
    case (resp_r)
      RESP_SERIAL: begin
        grp_limit = SERIAL_GROUPS;
        cur_word  = serial_words[serial_idx];
      end
      RESP_VERSION: begin
        grp_limit = VERSION_GROUPS;
        cur_word  = version_words[version_idx];
      end
      RESP_STATUS: begin
        grp_limit = STATUS_GROUPS;
        cur_word  = grp_r[0] ? status_lo : status_hi;
      end
      default: begin
        grp_limit = '0;
        cur_word  = 16'h0000;
      end
    endcase
  end

  crc8_pair u_crc (
    .i_word (cur_word),
    .o_crc  (cur_crc)
  );

  assign in_range = (grp_r < grp_limit);
  assign cur_byte = (pos_r == POS_MSB) ? cur_word[15:8] :
                    (pos_r == POS_LSB) ? cur_word[7:0]  :
                    cur_crc;

  // next-state decode; the flops below only load these values
  logic [STATUS_W-1:0] snap_nxt;
  logic                delay_restart;
  logic                delay_run;
  logic                delay_end;
  logic [CNT_W-1:0]    delay_cnt_nxt;
  logic                ready_nxt;
  logic                busy_end;
  logic [CNT_W-1:0]    busy_cnt_nxt;
  logic                busy_nxt;
  logic                soft_rst_nxt;
  logic                rd_good;
  logic                walk_clear;
  logic                walk_step;
  logic [GRP_W-1:0]    grp_nxt;
  logic [1:0]          pos_nxt;
  logic                rd_valid_nxt;
  logic                rd_nack_nxt;
  logic [7:0]          rd_data_nxt;

  // snapshot holds the value before a read-and-clear of the same cycle; a reset command zeroes it
  assign snap_nxt = (is_read_st | is_clear_st) ? flags :
                    is_reset                   ? '0    :
                    snap_r;

  // a new read command restarts the delay, a reset command drops it
  assign delay_restart = is_read_cmd | is_reset;
  assign delay_run     = ~ready_r & (resp_r != RESP_NONE);
  assign delay_end     = (delay_cnt_r == CNT_W'(P_READ_DELAY_CYC - 1));
  assign delay_cnt_nxt = delay_restart ? '0                 :
                         delay_run     ? delay_cnt_r + 1'b1 :
                         delay_cnt_r;
  assign ready_nxt     = delay_restart ? 1'b0      :
                         delay_run     ? delay_end :
                         ready_r;

  // commands stay locked out for the whole reset span
  assign busy_end     = (busy_cnt_r == CNT_W'(P_RESET_CYC - 1));
  assign busy_cnt_nxt = is_reset ? '0                :
                        busy_r   ? busy_cnt_r + 1'b1 :
                        busy_cnt_r;
  assign busy_nxt     = is_reset | (busy_r & ~busy_end);
  assign soft_rst_nxt = is_reset;

  // a read in a command's take cycle would see the old response
  assign rd_good    = i_rd_req & ready_r & in_range & ~delay_restart;
  // a stop rewinds the walk so the next read starts over
  assign walk_clear = delay_restart | i_rd_stop;
  assign walk_step  = rd_good & (pos_r == POS_CRC);
  assign pos_nxt    = (walk_clear | walk_step) ? POS_MSB      :
                      rd_good                  ? pos_r + 1'b1 :
                      pos_r;
  assign grp_nxt    = walk_clear ? '0           :
                      walk_step  ? grp_r + 1'b1 :
                      grp_r;

  // every request is answered; refused ones carry the idle byte
  assign rd_valid_nxt = i_rd_req;
  assign rd_nack_nxt  = i_rd_req & ~rd_good;
  assign rd_data_nxt  = rd_good ? cur_byte : IDLE_BYTE;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      snap_r <= '0;
    end else begin
      snap_r <= snap_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      resp_r <= RESP_NONE;
    end else begin
      resp_r <= resp_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      delay_cnt_r <= '0;
      ready_r     <= 1'b0;
    end else begin
      delay_cnt_r <= delay_cnt_nxt;
      ready_r     <= ready_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= '0;
      soft_rst_r <= 1'b0;
    end else begin
      busy_r     <= busy_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      soft_rst_r <= soft_rst_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      grp_r <= '0;
      pos_r <= POS_MSB;
    end else begin
      grp_r <= grp_nxt;
      pos_r <= pos_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_data_r  <= IDLE_BYTE;
      rd_valid_r <= 1'b0;
      rd_nack_r  <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_nack_r  <= rd_nack_nxt;
    end
  end

  // flags pass through a keeper flop already, outputs stay registered
  assign o_rd_data      = rd_data_r;
  assign o_rd_valid     = rd_valid_r;
  assign o_rd_nack      = rd_nack_r;
  assign o_data_ready   = ready_r;
  assign o_busy         = busy_r;
  assign o_soft_rst     = soft_rst_r;
  assign o_status_flags = flags;

endmodule : sensor_info_status_commands
`default_nettype wire

// ### sensor_info_status_commands_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_info_status_commands_checker
  import sensor_cmd_pkg::*;
#(
  parameter int unsigned P_READ_DELAY_CYC = 8,
  parameter int unsigned P_RESET_CYC      = 16
) (
  input wire logic                                i_core_clk,
  input wire logic                                i_sys_rst,
  input wire logic                                i_cmd_valid,
  input wire logic [15:0]                         i_cmd_word,
  input wire logic                                i_rd_req,
  input wire logic                                i_rd_stop,
  input wire logic [sensor_cmd_pkg::STATUS_W-1:0] i_status_cond,
  input wire logic [7:0]                          o_rd_data,
  input wire logic                                o_rd_valid,
  input wire logic                                o_rd_nack,
  input wire logic                                o_data_ready,
  input wire logic                                o_busy,
  input wire logic                                o_soft_rst,
  input wire logic [sensor_cmd_pkg::STATUS_W-1:0] o_status_flags
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire take = i_cmd_valid && !o_busy;
  wire rst_cmd = take && (i_cmd_word == CMD_DEVICE_RESET);
  wire rd_cmd = take && (i_cmd_word == CMD_GET_SERIAL || i_cmd_word == CMD_GET_VERSION
                || i_cmd_word == CMD_READ_STATUS || i_cmd_word == CMD_CLEAR_STATUS);
  // reset processing may wipe flags, so those cycles are left out
  wire clr = (take && i_cmd_word == CMD_CLEAR_STATUS) || rst_cmd || o_soft_rst || o_busy;
  wire [31:0] em = ERROR_FLAG_MASK;
  a_rd_answered: assert property (i_rd_req |=> o_rd_valid)
    else $error("read request not answered");
  a_nack_idle_byte: assert property (o_rd_nack |-> o_rd_valid && o_rd_data == IDLE_BYTE)
    else $error("refused byte not idle");
  a_early_read_nack: assert property (i_rd_req && !o_data_ready |=> o_rd_nack)
    else $error("byte given before read delay");
  a_ready_after_delay: assert property (rd_cmd |=> !o_data_ready ##[1:1000] o_data_ready)
    else $error("read delay handling wrong");
  a_soft_rst_pulse: assert property (rst_cmd |=> o_soft_rst && o_busy ##1 !o_soft_rst)
    else $error("reset command not processed");
  a_busy_span: assert property ($rose(o_busy) |-> o_busy [*8] ##[1:1000] !o_busy)
    else $error("busy span wrong");
  a_err_sticky: assert property (!clr |=> (o_status_flags & $past(o_status_flags) & em)
    == ($past(o_status_flags) & em))
    else $error("error flag lost");
  a_err_set: assert property (!o_busy && !o_soft_rst |=> (o_status_flags & $past(i_status_cond)
    & em) == ($past(i_status_cond) & em))
    else $error("error flag not set");
  a_plain_follow: assert property (!clr |=> (o_status_flags & ~em)
    == ($past(i_status_cond) & ~em))
    else $error("plain flag not following");
  c_reset_cmd: cover property (rst_cmd);
  c_clear_cmd: cover property (take && i_cmd_word == CMD_CLEAR_STATUS);
  c_good_byte: cover property (o_rd_valid && !o_rd_nack);
endmodule : sensor_info_status_commands_checker
bind sensor_info_status_commands sensor_info_status_commands_checker #(
  .P_READ_DELAY_CYC(P_READ_DELAY_CYC), .P_RESET_CYC(P_RESET_CYC)) checker_inst (.*);
`default_nettype wire

// ### host_cmd_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_rd_data,
  input  wire logic        i_rd_nack,
  input  wire logic        i_data_ready,
  input  wire logic        i_busy,
  output var  logic        o_cmd_valid,
  output var  logic [15:0] o_cmd_word,
  output var  logic        o_rd_req,
  output var  logic        o_rd_stop
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_word = 16'h0000;
    o_rd_req = 1'b0;
    o_rd_stop = 1'b0;
  end
  // word already joined msb first; released word inverted
  task send(input logic [15:0] w);
    @(posedge i_core_clk) #1;
    o_cmd_valid = 1'b1;
    o_cmd_word = w;
    @(posedge i_core_clk) #1;
    o_cmd_valid = 1'b0;
    o_cmd_word = ~w;
  endtask : send
  // raw bytes back; padding is checked byte by byte like the rest
  task rd(output logic [7:0] b, output logic nk, input int gap);
    repeat (gap) @(posedge i_core_clk);
    @(posedge i_core_clk) #1;
    o_rd_req = 1'b1;
    @(posedge i_core_clk) #1;
    o_rd_req = 1'b0;
    b = i_rd_data;
    nk = i_rd_nack;
  endtask : rd
  task stop;
    @(posedge i_core_clk) #1;
    o_rd_stop = 1'b1;
    @(posedge i_core_clk) #1;
    o_rd_stop = 1'b0;
  endtask : stop
  // sel 0 waits read delay, sel 1 waits end of reset processing
  task wait_lvl(input logic sel, output logic ok);
    ok = 1'b0;
    repeat (1000) begin
      @(posedge i_core_clk) #1;
      if ((sel ? !i_busy : i_data_ready) === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask : wait_lvl
endmodule : host_cmd_model
`default_nettype wire

// ### sensor_info_status_commands_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_info_status_commands_tb;
  import sensor_cmd_pkg::*;
  localparam logic [255:0] SER = {"AB12", 224'h0};
  localparam logic [63:0] VER = {FW_MAJOR_DEF, FW_MINOR_DEF, 8'h01, HW_MAJOR_DEF,
                                 HW_MINOR_DEF, PR_MAJOR_DEF, PR_MINOR_DEF, PAD_BYTE};
  logic        clk;
  logic        rst;
  logic [31:0] cond;
  logic        ok;
  wire         cv, rq, sp, vl, nk, rdy, bsy, srst;
  wire  [15:0] cw;
  wire  [7:0]  rdat;
  wire  [31:0] flg;
  int          bad_count;
  int          total_checks;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sensor_info_status_commands #(.P_READ_DELAY_CYC(8), .P_RESET_CYC(16), .P_SERIAL(SER),
    .P_FW_DEBUG(1'b1)) sensor_info_status_commands_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .i_cmd_valid(cv), .i_cmd_word(cw), .i_rd_req(rq), .i_rd_stop(sp), .i_status_cond(cond),
    .o_rd_data(rdat), .o_rd_valid(vl), .o_rd_nack(nk), .o_data_ready(rdy), .o_busy(bsy),
    .o_soft_rst(srst), .o_status_flags(flg));
  host_cmd_model host_cmd_model_inst (.i_core_clk(clk), .i_rd_data(rdat), .i_rd_nack(nk),
    .i_data_ready(rdy), .i_busy(bsy), .o_cmd_valid(cv), .o_cmd_word(cw), .o_rd_req(rq),
    .o_rd_stop(sp));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task rd_groups(input int n, input logic [255:0] d, input int gap);
    logic [15:0] w;
    logic [7:0]  b, e;
    logic        k;
    for (int g = 0; g < n; g++) begin
      w = d[255-16*g -: 16];
      for (int p = 0; p < 3; p++) begin
        host_cmd_model_inst.rd(b, k, gap);
        e = (p == 0) ? w[15:8] : (p == 1) ? w[7:0] : crc8(w);
        chk("resp_byte", {22'h0, 2'b10, e}, {22'h0, vl, k, b});
      end
    end
  endtask : rd_groups
  task refused(input string n);
    logic [7:0] b;
    logic       k;
    host_cmd_model_inst.rd(b, k, 0);
    chk(n, 32'h3FF, {22'h0, vl, k, b});
  endtask : refused
  task start(input logic [15:0] w);
    host_cmd_model_inst.send(w);
    host_cmd_model_inst.wait_lvl(1'b0, ok);
    chk("ready", 32'h1, {31'h0, ok});
  endtask : start
  task t_serial;
    chk("crc_example", 32'h92, {24'h0, crc8(16'hBEEF)});
    host_cmd_model_inst.send(CMD_GET_SERIAL);
    refused("early_read");
    host_cmd_model_inst.wait_lvl(1'b0, ok);
    rd_groups(16, SER, 0);
    refused("past_serial_end");
  endtask : t_serial
  task t_version;
    start(CMD_GET_VERSION);
    rd_groups(4, {VER, 192'h0}, 2);
    refused("past_version_end");
  endtask : t_version
  task t_status;
    cond = 32'h8001_0003;
    repeat (2) @(posedge clk);
    #1 cond = 32'h0000_0001;
    repeat (2) @(posedge clk);
    #1 chk("flags_mix", 32'h8001_0001, flg);
    start(CMD_READ_STATUS);
    rd_groups(1, {32'h8001_0001, 224'h0}, 0);
    host_cmd_model_inst.stop();
    rd_groups(2, {32'h8001_0001, 224'h0}, 1);
    chk("flags_kept", 32'h8001_0001, flg);
    start(CMD_CLEAR_STATUS);
    rd_groups(2, {32'h8001_0001, 224'h0}, 0);
    chk("flags_cleared", 32'h0000_0001, flg);
  endtask : t_status
  task t_reset;
    cond = 32'h0001_0000;
    @(posedge clk);
    #1 cond = 32'h0;
    repeat (2) @(posedge clk);
    #1 chk("flags_before_rst", 32'h0001_0000, flg);
    host_cmd_model_inst.send(CMD_DEVICE_RESET);
    chk("soft_rst_busy", 32'h3, {30'h0, srst, bsy});
    host_cmd_model_inst.send(CMD_GET_SERIAL);
    host_cmd_model_inst.wait_lvl(1'b1, ok);
    chk("busy_end", 32'h1, {31'h0, ok});
    chk("flags_reset", 32'h0, flg);
    refused("cmd_in_busy");
  endtask : t_reset
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    cond = 32'h0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_serial();
    t_version();
    t_status();
    t_reset();
    print_verdict();
  end
endmodule : sensor_info_status_commands_tb
`default_nettype wire
